// *** dv/sesm_chk_monitor.sv ***
// Purpose: Port checker for the excitation and stability block
// Assumes: One clock domain, reset asynchronous and active high
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module sesm_chk
  import sesm_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire logic [31:0]        reg_wdata,
  input wire logic signed [31:0] current_excitation,
  input wire logic               velocity_injection_en,
  input wire logic [2:0]         excitation_mode,
  input wire logic               instability_fault,
  input wire logic               instability_fault_stb,
  input wire logic [7:0]         fault_code
);
  logic mode_wr;
  logic mode_bad;
  assign mode_wr  = reg_wr && reg_addr == OFS_MODE && reg_wdata <= 32'h5;
  assign mode_bad = reg_wr && reg_addr == OFS_MODE && reg_wdata > 32'h5;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence mode_wr_s;
    mode_wr;
  endsequence
  sequence mode_idle_s;
    (excitation_mode == 3'h0) [*3];
  endsequence
  fault_code_a: assert property (fault_code ==
    (instability_fault ? FAULT_INSTABILITY : 8'h00))
    else $error("fault code does not follow fault");
  fault_rise_a: assert property ($rose(instability_fault) |->
    instability_fault_stb) else $error("fault rose without pulse");
  fault_cause_a: assert property (instability_fault_stb |->
    $past(excitation_mode) == 3'h5 && !$past(instability_fault))
    else $error("fault pulse outside stability test");
  stb_single_a: assert property (instability_fault_stb |=>
    !instability_fault_stb) else $error("fault pulse too long");
  fault_hold_a: assert property (instability_fault && !mode_wr |=>
    instability_fault) else $error("fault dropped by itself");
  mode_legal_a: assert property (excitation_mode <= 3'h5)
    else $error("mode out of range");
  mode_write_a: assert property (mode_wr_s |=>
    excitation_mode == $past(reg_wdata[2:0]))
    else $error("mode write not taken");
  mode_refuse_a: assert property (mode_bad |=>
    $stable(excitation_mode)) else $error("bad mode write taken");
  idle_quiet_a: assert property (mode_idle_s |->
    current_excitation == 32'sh0 && !velocity_injection_en)
    else $error("excitation while off");
endmodule : sesm_chk

bind sesm_monitor sesm_chk u_chk (
  .clk                   (clk),
  .rst                   (rst),
  .reg_addr              (reg_addr),
  .reg_wr                (reg_wr),
  .reg_wdata             (reg_wdata),
  .current_excitation    (current_excitation),
  .velocity_injection_en (velocity_injection_en),
  .excitation_mode       (excitation_mode),
  .instability_fault     (instability_fault),
  .instability_fault_stb (instability_fault_stb),
  .fault_code            (fault_code)
);

// *** dv/sesm_loop_model.sv ***
// Purpose: Control loop side: sample tick, current command, peaks
// Assumes: Tick every PER clocks, command follows the bench request
// Notes:   Peaks fixed per instance
`timescale 1ns/1ps
module sesm_loop_model #(
  parameter int          PER = 8,
  parameter logic [31:0] DPK = 32'h0000_1388,
  parameter logic [31:0] MPK = 32'h0000_0BB8
)(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic signed [31:0] cur_req,
  output logic                    drive_sample_stb,
  output logic signed [31:0]      commanded_drive_current,
  output logic [31:0]             drive_peak_current,
  output logic [31:0]             motor_peak_current
);
  logic [7:0] cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 8'h00;
    else cnt_reg <= (cnt_reg == 8'(PER - 1)) ? 8'h00 : cnt_reg + 8'h01;
  end
  assign drive_sample_stb        = (cnt_reg == 8'(PER - 1));
  assign commanded_drive_current = cur_req;
  assign drive_peak_current      = DPK;
  assign motor_peak_current      = MPK;
endmodule : sesm_loop_model

// *** dv/sesm_monitor_tb.sv ***
// Purpose: Self-checking bench of the excitation and stability block
// Assumes: Peaks 5000 mA and 3000 mA, tick every 8 clocks, 10 clk per ms
// Notes:   Register table loop first, then hand-written cases
`timescale 1ns/1ps
module sesm_monitor_tb
  import sesm_pkg::*;
;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } sesm_row_s;
  logic clk, rst, reg_wr, reg_rd, stb, vel, flt, flt_stb;
  logic [7:0] reg_addr, fcode;
  logic [31:0] reg_wdata, reg_rdata, dpk, mpk;
  logic signed [31:0] cur, cur_req, exc, mx;
  logic [2:0] mode;
  int n_errors, n_checks, cyc, n, n_stb;
  sesm_row_s rows [17] = '{
    '{1'b0, OFS_FREQ, 32'h0, 32'h0}, '{1'b0, OFS_IAMP, 32'h0, 32'hC8},
    '{1'b0, OFS_INJECT, 32'h0, 32'h0}, '{1'b0, OFS_MODE, 32'h0, 32'h0},
    '{1'b0, OFS_IFLIMIT, 32'h0, 32'h0}, '{1'b0, OFS_IFTHRESH, 32'h0, 32'h0},
    '{1'b1, OFS_FREQ, 32'h320000, 32'h320000},
    '{1'b1, OFS_FREQ, 32'h23280000, 32'h1F400000},
    '{1'b1, OFS_IAMP, 32'h12C, 32'h12C}, '{1'b1, OFS_INJECT, 32'h1, 32'h1},
    '{1'b1, OFS_INJECT, 32'h3, 32'h1}, '{1'b1, OFS_MODE, 32'h6, 32'h0},
    '{1'b1, OFS_IFLIMIT, 32'h0, 32'h1},
    '{1'b1, OFS_IFLIMIT, 32'h11170, 32'hEA60},
    '{1'b1, OFS_IFTHRESH, 32'h0, 32'h1},
    '{1'b1, OFS_IFTHRESH, 32'h1388, 32'hBB8},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h0}};
  sesm_loop_model u_loop (.clk(clk), .rst(rst), .cur_req(cur_req),
    .drive_sample_stb(stb), .commanded_drive_current(cur),
    .drive_peak_current(dpk), .motor_peak_current(mpk));
  sesm_monitor #(.CYC_PER_MS_P(10), .SAMPLES_PER_MS_P(16)) uut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .drive_sample_stb(stb), .commanded_drive_current(cur),
    .drive_peak_current(dpk), .motor_peak_current(mpk),
    .current_excitation(exc), .velocity_injection_en(vel),
    .excitation_mode(mode), .instability_fault(flt),
    .instability_fault_stb(flt_stb), .fault_code(fcode));
  always #2 clk = ~clk;
  always @(negedge clk) begin
    if (flt_stb === 1'b1) n_stb++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(reg_rdata, e);
  endtask : rdchk
  task automatic wait_stb(input int k);
    int s;
    s = 0;
    while (s < k) begin
      if (stb) s++;
      @(negedge clk);
    end
  endtask : wait_stb
  task automatic fcount(output int c);
    c = 0;
    repeat (600) begin
      if (flt === 1'b1) break;
      if (stb) c++;
      @(negedge clk);
    end
  endtask : fcount
  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    cur_req = 32'sh0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    wr(OFS_IAMP, 32'h1388);
    wr(OFS_MODE, 32'h4);
    wait_stb(3);
    check(exc, 32'hBB8);
    wr(OFS_IAMP, 32'hFFFFEC78);
    wait_stb(3);
    check(exc, 32'hFFFFF448);
    wr(OFS_IAMP, 32'h12C);
    wr(OFS_MODE, 32'h1);
    wait_stb(3);
    check(32'(exc == 300 || exc == -300), 32'h1);
    wr(OFS_INJECT, 32'h2);
    wait_stb(3);
    check(32'(vel), 32'h1);
    check(exc, 32'h0);
    wr(OFS_INJECT, 32'h1);
    wr(OFS_IAMP, 32'h12C);
    wr(OFS_FREQ, 32'h0FA00000);
    wr(OFS_MODE, 32'h2);
    mx = 32'sh0;
    repeat (80) begin
      @(negedge clk);
      if ((exc < 0 ? -exc : exc) > mx) mx = (exc < 0 ? -exc : exc);
    end
    check(32'(mx > 0 && mx <= 300), 32'h1);
    wr(OFS_WDOG, 32'h5);
    wr(OFS_MODE, 32'h1);
    repeat (30) @(negedge clk);
    wr(OFS_MODE, 32'h1);
    repeat (35) @(negedge clk);
    check(32'(mode), 32'h1);
    repeat (30) @(negedge clk);
    check(32'(mode), 32'h0);
    wr(OFS_WDOG, 32'h0);
    wr(OFS_IFTHRESH, 32'h64);
    wr(OFS_IFLIMIT, 32'h1);
    cur_req = 32'sd200;
    wr(OFS_MODE, 32'h5);
    fcount(n);
    check(32'(n), 32'd16);
    check(32'(fcode), 32'h85);
    rdchk(OFS_STATUS, 32'h3);
    cur_req = 32'sd0;
    wr(OFS_MODE, 32'h0);
    check(32'(flt), 32'h0);
    cur_req = 32'sd200;
    wr(OFS_MODE, 32'h5);
    wait_stb(10);
    cur_req = 32'sd100;
    wait_stb(1);
    cur_req = 32'sd200;
    fcount(n);
    check(32'(n), 32'd16);
    @(negedge clk);
    check(32'(n_stb), 32'd2);
    rst = 1'b1;
    @(negedge clk);
    check(32'(flt), 32'h0);
    check(32'(mode), 32'h0);
    rst = 1'b0;
    rdchk(OFS_IAMP, 32'hC8);
    tally_and_finish();
  end
endmodule : sesm_monitor_tb

// *** include/sesm_pkg.sv ***
// Purpose: Shared constants and types of the excitation / stability block
// Assumes: 250 MHz core clock, 16 kHz drive sample strobe
// Notes:   Currents in mA, frequency in 1/65536 Hz, times in ms
package sesm_pkg;

  // Register offsets
  localparam logic [7:0]  OFS_FREQ      = 8'h28;
  localparam logic [7:0]  OFS_IAMP      = 8'h2A;
  localparam logic [7:0]  OFS_INJECT    = 8'h2C;
  localparam logic [7:0]  OFS_MODE      = 8'h2E;
  localparam logic [7:0]  OFS_WDOG      = 8'h30;
  localparam logic [7:0]  OFS_IFLIMIT   = 8'h32;
  localparam logic [7:0]  OFS_IFTHRESH  = 8'h34;
  localparam logic [7:0]  OFS_STATUS    = 8'h36;

  // Reset values
  localparam logic [31:0] RST_FREQ      = 32'h0000_0000;
  localparam logic [31:0] RST_IAMP      = 32'h0000_00C8;
  localparam logic [31:0] RST_IFLIMIT   = 32'h0000_0000;
  localparam logic [31:0] RST_IFTHRESH  = 32'h0000_0000;
  localparam logic [28:0] RST_WDOG      = 29'h0000_0000;
  localparam logic [15:0] RST_LFSR      = 16'hACE1;

  // Accepted ranges
  localparam logic [31:0] FREQ_MAX      = 32'h1F40_0000;
  localparam logic [31:0] IFLIMIT_MIN   = 32'h0000_0001;
  localparam logic [31:0] IFLIMIT_MAX   = 32'h0000_EA60;
  localparam logic [31:0] IFTHRESH_MIN  = 32'h0000_0001;
  localparam logic [31:0] WDOG_MAX      = 32'h1000_0000;

  // Status field positions
  localparam int          STAT_FAULT_BIT = 0;
  localparam int          STAT_OVER_BIT  = 1;

  // Fault code for instability during the stability test
  localparam logic [7:0]  FAULT_INSTABILITY = 8'h85;

  // Timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          MS_NS          = 1000000;
  localparam int          CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
  localparam int          SAMPLE_HZ      = 16000;
  localparam int          SAMPLES_PER_MS = SAMPLE_HZ / 1000;

  typedef enum logic [2:0] {
    SESM_MODE_OFF    = 3'b000,
    SESM_MODE_PRB    = 3'b001,
    SESM_MODE_SINE   = 3'b010,
    SESM_MODE_NOISE  = 3'b011,
    SESM_MODE_OFFSET = 3'b100,
    SESM_MODE_STAB   = 3'b101
  } sesm_mode_e;

  typedef enum logic [1:0] {
    SESM_INJ_NONE = 2'b00,
    SESM_INJ_CUR  = 2'b01,
    SESM_INJ_VEL  = 2'b10
  } sesm_inject_e;

endpackage : sesm_pkg

// *** rtl/sesm_monitor.sv ***
// Purpose: Excitation source and current stability monitor
// Assumes: Commanded current and peaks come from logic on clk, in mA
// Notes:   Registers reached by a simple address/strobe port
//
// Operation
// RULE1: Sine frequency zero to 8000 Hz, resets zero
// RULE2: Current injection uses current amplitude, default 0.2A
// RULE3: Amplitude clamped to lower combined current limit
// RULE4: Binary mode with current injection uses amplitude
// RULE5: Injection select: none, current, velocity; resets none
// RULE6: Mode 5 compares commanded current against threshold
// RULE7: Over threshold in test accumulates duration counter
// RULE8: Counter reaching limit raises fault code 133
// RULE9: Duration limit 0.001 to 60 s, resets zero
// RULE10: Threshold 0.001 A to lower peak, resets zero
// RULE11: Host sets injection, amplitude, frequency, then sine
// RULE12: Mode decode: off, binary, sine, noise, offset
// RULE13: Watchdog turns mode off; nonzero mode write restarts
// RULE14: Counter clears at or below threshold, leaving test
// RULE15: Counter steps per drive sample against limit
`timescale 1ns/1ps
module sesm_monitor
  import sesm_pkg::*;
#(
  parameter int CYC_PER_MS_P     = CYC_PER_MS,
  parameter int SAMPLES_PER_MS_P = SAMPLES_PER_MS
)(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [7:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               drive_sample_stb,
  input  wire logic signed [31:0] commanded_drive_current,
  input  wire logic [31:0]        drive_peak_current,
  input  wire logic [31:0]        motor_peak_current,
  output logic signed [31:0]      current_excitation,
  output logic                    velocity_injection_en,
  output logic [2:0]              excitation_mode,
  output logic                    instability_fault,
  output logic                    instability_fault_stb,
  output logic [7:0]              fault_code
);

  if (CYC_PER_MS_P < 1 || CYC_PER_MS_P > 262144) begin : g_chk_ms
    $error("CYC_PER_MS_P out of range");
  end
  if (SAMPLES_PER_MS_P < 1 || SAMPLES_PER_MS_P > 1024) begin : g_chk_sp
    $error("SAMPLES_PER_MS_P out of range");
  end

  function automatic logic [31:0] umin(input logic [31:0] a,
                                       input logic [31:0] b);
    umin = (a < b) ? a : b;
  endfunction : umin

  function automatic logic [31:0] clampu(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    clampu = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampu

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    mag = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  function automatic logic [31:0] phase_step(input logic [31:0] f);
    logic [47:0] t;
    t = {f, 16'h0000} / 48'(SAMPLE_HZ);
    phase_step = t[31:0];
  endfunction : phase_step

  // Parameter registers
  logic [31:0]  freq_reg,    freq_next;
  logic [31:0]  step_reg,    step_next;
  logic [31:0]  iamp_reg,    iamp_next;
  sesm_inject_e inject_reg,  inject_next;
  sesm_mode_e   mode_reg,    mode_next;
  logic [28:0]  wdog_reg,    wdog_next;
  logic [31:0]  limit_reg,   limit_next;
  logic [31:0]  thresh_reg,  thresh_next;
  logic [31:0]  rdata_reg,   rdata_next;
  // Watchdog timers
  logic [17:0]  pre_reg,     pre_next;
  logic [28:0]  ms_reg,      ms_next;
  // Stability monitor
  logic [31:0]  dur_reg,     dur_next;
  logic         fault_reg,   fault_next;
  logic         fstb_reg,    fstb_next;
  // Waveform
  logic [31:0]  phase_reg,   phase_next;
  logic [15:0]  lfsr_reg,    lfsr_next;
  logic [31:0]  exc_reg,     exc_next;
  logic         vel_reg,     vel_next;

  logic [31:0]  cur_lim;
  logic         wr_mode;
  logic         wdog_expire;
  logic         stab_active;
  logic         over_thresh;
  logic [31:0]  limit_samples;
  logic signed [31:0] amp_c;
  logic signed [15:0] sine_q15;
  logic signed [47:0] prod;

  assign cur_lim = umin(drive_peak_current, motor_peak_current);
  assign wr_mode = reg_wr && (reg_addr == OFS_MODE) &&
                   (reg_wdata <= 32'(SESM_MODE_STAB));

  // Register writes and reads
  always_comb begin
    freq_next   = freq_reg;
    iamp_next   = iamp_reg;
    inject_next = inject_reg;
    mode_next   = mode_reg;
    wdog_next   = wdog_reg;
    limit_next  = limit_reg;
    thresh_next = thresh_reg;
    rdata_next  = rdata_reg;
    if (wdog_expire) begin
      mode_next = SESM_MODE_OFF; // RULE13
    end
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_FREQ:     freq_next = umin(reg_wdata, FREQ_MAX); // RULE1
        OFS_IAMP:     iamp_next = reg_wdata; // RULE2
        OFS_INJECT: begin
          if (reg_wdata <= 32'(SESM_INJ_VEL)) begin
            inject_next = sesm_inject_e'(reg_wdata[1:0]); // RULE5
          end
        end
        OFS_MODE: begin
          if (wr_mode) begin
            mode_next = sesm_mode_e'(reg_wdata[2:0]); // RULE12
          end
        end
        OFS_WDOG:
          wdog_next = 29'(umin(reg_wdata, WDOG_MAX));
        OFS_IFLIMIT:  // RULE9
          limit_next = clampu(reg_wdata, IFLIMIT_MIN, IFLIMIT_MAX);
        OFS_IFTHRESH: // RULE10
          thresh_next = clampu(reg_wdata, IFTHRESH_MIN, cur_lim);
        default: ;
      endcase
    end
    step_next = phase_step(freq_reg);
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_FREQ:     rdata_next = freq_reg;
        OFS_IAMP:     rdata_next = iamp_reg;
        OFS_INJECT:   rdata_next = {30'h0, inject_reg};
        OFS_MODE:     rdata_next = {29'h0, mode_reg};
        OFS_WDOG:     rdata_next = {3'h0, wdog_reg};
        OFS_IFLIMIT:  rdata_next = limit_reg;
        OFS_IFTHRESH: rdata_next = thresh_reg;
        OFS_STATUS: begin
          rdata_next = 32'h0;
          rdata_next[STAT_FAULT_BIT] = fault_reg;
          rdata_next[STAT_OVER_BIT]  = over_thresh;
        end
        default:      rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_reg   <= RST_FREQ;
      step_reg   <= 32'h0;
      iamp_reg   <= RST_IAMP;
      inject_reg <= SESM_INJ_NONE;
      mode_reg   <= SESM_MODE_OFF;
      wdog_reg   <= RST_WDOG;
      limit_reg  <= RST_IFLIMIT;
      thresh_reg <= RST_IFTHRESH;
      rdata_reg  <= 32'h0;
    end else begin
      freq_reg   <= freq_next;
      step_reg   <= step_next;
      iamp_reg   <= iamp_next;
      inject_reg <= inject_next;
      mode_reg   <= mode_next;
      wdog_reg   <= wdog_next;
      limit_reg  <= limit_next;
      thresh_reg <= thresh_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Mode watchdog: counts ms while a nonzero mode is held
  assign wdog_expire = (wdog_reg != 29'h0) &&
                       (mode_reg != SESM_MODE_OFF) &&
                       (ms_reg >= wdog_reg) && !wr_mode;

  always_comb begin
    pre_next = pre_reg;
    ms_next  = ms_reg;
    if (wr_mode || mode_reg == SESM_MODE_OFF || wdog_reg == 29'h0) begin
      pre_next = 18'h0; // RULE13
      ms_next  = 29'h0;
    end else if (pre_reg == 18'(CYC_PER_MS_P - 1)) begin
      pre_next = 18'h0;
      if (ms_reg < wdog_reg) begin
        ms_next = 29'(ms_reg + 29'h1);
      end
    end else begin
      pre_next = 18'(pre_reg + 18'h1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 18'h0;
      ms_reg  <= 29'h0;
    end else begin
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
    end
  end

  // Stability test
  assign stab_active   = (mode_reg == SESM_MODE_STAB); // RULE6
  assign over_thresh   = mag(commanded_drive_current) > thresh_reg; // RULE6
  assign limit_samples = 32'(limit_reg * 32'(SAMPLES_PER_MS_P)); // RULE15

  always_comb begin
    dur_next   = dur_reg;
    fault_next = fault_reg;
    fstb_next  = 1'b0;
    if (!stab_active || !over_thresh) begin
      dur_next = 32'h0; // RULE14
    end else if (drive_sample_stb && dur_reg < limit_samples) begin
      dur_next = 32'(dur_reg + 32'h1); // RULE7 RULE15
    end
    if (wr_mode) begin
      fault_next = 1'b0;
    end
    if (stab_active && over_thresh && limit_reg != 32'h0 &&
        dur_reg >= limit_samples) begin
      fault_next = 1'b1; // RULE8
      fstb_next  = !fault_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dur_reg   <= 32'h0;
      fault_reg <= 1'b0;
      fstb_reg  <= 1'b0;
    end else begin
      dur_reg   <= dur_next;
      fault_reg <= fault_next;
      fstb_reg  <= fstb_next;
    end
  end

  // Waveform generation
  sesm_sine_rom u_rom (
    .clk  (clk),
    .rst  (rst),
    .addr (phase_reg[31:26]),
    .data (sine_q15)
  );

  always_comb begin
    amp_c = $signed(iamp_reg);
    if (amp_c > $signed({1'b0, cur_lim[30:0]})) begin
      amp_c = $signed({1'b0, cur_lim[30:0]}); // RULE3
    end else if (amp_c < -$signed({1'b0, cur_lim[30:0]})) begin
      amp_c = -$signed({1'b0, cur_lim[30:0]}); // RULE3
    end
    phase_next = phase_reg;
    lfsr_next  = lfsr_reg;
    if (drive_sample_stb) begin
      phase_next = 32'(phase_reg + step_reg); // RULE1
      lfsr_next  = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                    lfsr_reg[12] ^ lfsr_reg[10]};
    end
    prod     = 48'sh0;
    exc_next = 32'h0;
    unique case (mode_reg)
      SESM_MODE_PRB:   exc_next = lfsr_reg[0] ? amp_c : -amp_c; // RULE4
      SESM_MODE_SINE: begin
        prod     = amp_c * sine_q15;
        exc_next = prod[46:15]; // RULE2
      end
      SESM_MODE_NOISE: begin
        prod     = amp_c * $signed(lfsr_reg);
        exc_next = prod[46:15];
      end
      SESM_MODE_OFFSET: exc_next = amp_c; // RULE12
      default:          exc_next = 32'h0;
    endcase
    if (inject_reg != SESM_INJ_CUR && mode_reg != SESM_MODE_OFFSET) begin
      exc_next = 32'h0; // RULE5
    end
    vel_next = (inject_reg == SESM_INJ_VEL) &&
               (mode_reg inside {SESM_MODE_PRB, SESM_MODE_SINE,
                                 SESM_MODE_NOISE}); // RULE5
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 32'h0;
      lfsr_reg  <= RST_LFSR;
      exc_reg   <= 32'h0;
      vel_reg   <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      lfsr_reg  <= lfsr_next;
      exc_reg   <= exc_next;
      vel_reg   <= vel_next;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign current_excitation    = $signed(exc_reg);
  assign velocity_injection_en = vel_reg;
  assign excitation_mode       = mode_reg;
  assign instability_fault     = fault_reg;
  assign instability_fault_stb = fstb_reg;
  assign fault_code            = fault_reg ? FAULT_INSTABILITY : 8'h00;

endmodule : sesm_monitor

// *** rtl/sesm_sine_rom.sv ***
// Purpose: 64-point sine table with registered read data
// Assumes: Q15 output, quarter wave stored
// Notes:   One cycle read latency
`timescale 1ns/1ps
module sesm_sine_rom
  import sesm_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [5:0]         addr,
  output logic signed [15:0]      data
);

  logic signed [15:0] data_next;
  logic        [4:0]  qidx;

  function automatic logic [15:0] quarter(input logic [4:0] i);
    unique case (i)
      5'h00:   quarter = 16'h0000;
      5'h01:   quarter = 16'h0C8C;
      5'h02:   quarter = 16'h18F9;
      5'h03:   quarter = 16'h2528;
      5'h04:   quarter = 16'h30FB;
      5'h05:   quarter = 16'h3C56;
      5'h06:   quarter = 16'h471C;
      5'h07:   quarter = 16'h5133;
      5'h08:   quarter = 16'h5A82;
      5'h09:   quarter = 16'h62F1;
      5'h0A:   quarter = 16'h6A6D;
      5'h0B:   quarter = 16'h70E2;
      5'h0C:   quarter = 16'h7641;
      5'h0D:   quarter = 16'h7A7C;
      5'h0E:   quarter = 16'h7D89;
      5'h0F:   quarter = 16'h7F61;
      default: quarter = 16'h7FFF;
    endcase
  endfunction : quarter

  // Mirror the quarter wave over the four quadrants
  always_comb begin
    qidx = addr[4] ? 5'(5'h10 - {1'b0, addr[3:0]}) : {1'b0, addr[3:0]};
    data_next = $signed(quarter(qidx));
    if (addr[5]) begin
      data_next = -$signed(quarter(qidx));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data <= 16'sh0000;
    end else begin
      data <= data_next;
    end
  end

endmodule : sesm_sine_rom
